// ---- design/d2cd_pkg.sv ----
// package for the command decoder: pin groups, command codes, register fields
package d2cd_pkg;

    // ----------------------------------------
    // widths and field positions
    // ----------------------------------------
    localparam int ADDR_W     = 14;
    localparam int BANK_W     = 3;
    localparam int COL_HI     = 9;
    localparam int AP_BIT     = 10;
    localparam int TEMP_BIT   = 7;
    localparam int PART_SEL_HI = 2;
    localparam int X16_TOP    = 12;
    localparam int X8_TOP     = 13;

    // ----------------------------------------
    // register selects and timing
    // ----------------------------------------
    localparam logic [2:0] SEL_MODE  = 3'h0;
    localparam logic [2:0] SEL_EXT1  = 3'h1;
    localparam logic [2:0] SEL_REFR  = 3'h2;
    localparam logic [2:0] SEL_SPARE = 3'h3;
    localparam int LINK_PERIOD_NS        = 160;
    localparam int SELF_REFRESH_EXIT_READ_DELAY_CLK = 200;
    localparam logic [7:0] SR_EXIT_CNT   = 8'(SELF_REFRESH_EXIT_READ_DELAY_CLK);

    // ----------------------------------------
    // decoded command codes
    // ----------------------------------------
    typedef enum logic [3:0] {
        D2CD_CMD_NONE  = 4'h0,
        D2CD_CMD_MODE_SET = 4'h1,
        D2CD_CMD_REF   = 4'h2,
        D2CD_CMD_SRE   = 4'h3,
        D2CD_CMD_SRX   = 4'h4,
        D2CD_CMD_ACT   = 4'h5,
        D2CD_CMD_PRE   = 4'h6,
        D2CD_CMD_PREA  = 4'h7,
        D2CD_CMD_WR    = 4'h8,
        D2CD_CMD_RD    = 4'h9,
        D2CD_CMD_PDE   = 4'hA,
        D2CD_CMD_PDX   = 4'hB,
        D2CD_CMD_ILL   = 4'hC
    } d2cd_cmd_type;

    typedef struct packed {
        d2cd_cmd_type        cmd;
        logic                auto_pre;
        logic [BANK_W-1:0]   bank;
        logic [ADDR_W-1:0]   addr;
    } d2cd_event_type;

    typedef struct packed {
        logic                high_temp_refresh_rate;
        logic [2:0]          partial_array_refresh_select;
    } d2cd_refr_type;

endpackage : d2cd_pkg

// ---- design/d2cd_top.sv ----
// command decoder with refresh-options and spare extended mode registers
`timescale 1ns/1ps
module d2cd_top #(
    parameter bit X16_ORG = 1'b0
) (
    input  wire logic                       MCLK,
    input  wire logic                       SRST,
    input  wire logic                       CK_LINK,
    input  wire logic                       CKE,
    input  wire logic                       CS_N,
    input  wire logic                       RAS_N,
    input  wire logic                       CAS_N,
    input  wire logic                       WE_N,
    input  wire logic                       ODT,
    input  wire logic [2:0]                 BA,
    input  wire logic [13:0]                ADDR,
    output logic                            EVT_TGL,
    output d2cd_pkg::d2cd_event_type        EVT,
    output d2cd_pkg::d2cd_refr_type         REFR_OPT,
    output logic                            REFR_VALID,
    output logic                            SPARE_VALID,
    output logic                            SELF_REFRESH,
    output logic                            POWER_DOWN,
    output logic                            ODT_EN,
    output logic                            READ_READY,
    output logic                            ILLEGAL
);

    // ----------------------------------------
    // link side: sample pins on the memory clock
    // ----------------------------------------
    // link_rst_r is the core reset brought into the link domain
    logic                       lrst_s1_r;
    logic                       link_rst_r;
    logic                       cke_prev_r;
    logic                       lk_self_r;
    logic                       lk_pd_r;
    logic                       lk_burst_r;
    logic                       lk_tgl_r;
    d2cd_pkg::d2cd_event_type   lk_evt_r;
    d2cd_pkg::d2cd_cmd_type     cmd_nxt;
    logic                       nop_or_desel;
    logic [13:0]                addr_m;

    always_ff @(posedge CK_LINK) begin
        lrst_s1_r  <= SRST;
        link_rst_r <= lrst_s1_r;
    end

    // the unused top pin on the x16 part is masked so row and opcode stay clean
    always_comb begin
        addr_m = ADDR;
        if (X16_ORG) begin
            addr_m[d2cd_pkg::X8_TOP] = 1'b0;
        end
    end

    assign nop_or_desel = CS_N || (RAS_N && CAS_N && WE_N);

    always_comb begin
        cmd_nxt = d2cd_pkg::D2CD_CMD_NONE;
        if (lk_self_r || lk_pd_r) begin
            if (CKE && nop_or_desel) begin
                cmd_nxt = lk_self_r ? d2cd_pkg::D2CD_CMD_SRX : d2cd_pkg::D2CD_CMD_PDX;
            end else if (CKE) begin
                cmd_nxt = d2cd_pkg::D2CD_CMD_ILL;
            end
        end else if (cke_prev_r && !CKE) begin
            if (nop_or_desel) begin
                cmd_nxt = d2cd_pkg::D2CD_CMD_PDE;
            end else if (!RAS_N && !CAS_N && WE_N) begin
                cmd_nxt = d2cd_pkg::D2CD_CMD_SRE;
            end else begin
                cmd_nxt = d2cd_pkg::D2CD_CMD_ILL;
            end
        end else if (cke_prev_r && !CS_N) begin
            unique case ({RAS_N, CAS_N, WE_N})
                3'h0: cmd_nxt = d2cd_pkg::D2CD_CMD_MODE_SET;
                3'h1: cmd_nxt = d2cd_pkg::D2CD_CMD_REF;
                3'h2: cmd_nxt = addr_m[d2cd_pkg::AP_BIT] ? d2cd_pkg::D2CD_CMD_PREA
                                                         : d2cd_pkg::D2CD_CMD_PRE;
                3'h3: cmd_nxt = d2cd_pkg::D2CD_CMD_ACT;
                3'h4: cmd_nxt = d2cd_pkg::D2CD_CMD_WR;
                3'h5: cmd_nxt = d2cd_pkg::D2CD_CMD_RD;
                3'h6: cmd_nxt = d2cd_pkg::D2CD_CMD_ILL;
                3'h7: cmd_nxt = d2cd_pkg::D2CD_CMD_NONE;
            endcase
        end
    end

    always_ff @(posedge CK_LINK) begin
        if (link_rst_r) begin
            cke_prev_r <= 1'b0;
            lk_self_r  <= 1'b0;
            lk_pd_r    <= 1'b0;
        end else begin
            cke_prev_r <= CKE;
            if (cmd_nxt == d2cd_pkg::D2CD_CMD_SRE) begin
                lk_self_r <= 1'b1;
            end else if (cmd_nxt == d2cd_pkg::D2CD_CMD_SRX) begin
                lk_self_r <= 1'b0;
            end
            if (cmd_nxt == d2cd_pkg::D2CD_CMD_PDE) begin
                lk_pd_r <= 1'b1;
            end else if (cmd_nxt == d2cd_pkg::D2CD_CMD_PDX) begin
                lk_pd_r <= 1'b0;
            end
        end
    end

    // one command per toggle; the core sees each event once while its clock runs more than three times the link clock
    always_ff @(posedge CK_LINK) begin
        if (link_rst_r) begin
            lk_tgl_r   <= 1'b0;
            lk_burst_r <= 1'b0;
            lk_evt_r   <= '0;
        end else begin
            lk_burst_r <= 1'b0;
            if (cmd_nxt != d2cd_pkg::D2CD_CMD_NONE) begin
                lk_tgl_r      <= ~lk_tgl_r;
                lk_evt_r.cmd  <= cmd_nxt;
                lk_evt_r.bank <= BA;
                lk_evt_r.addr <= addr_m;
                lk_evt_r.auto_pre <= addr_m[d2cd_pkg::AP_BIT];
                // a second burst command right after one is flagged rather than cutting it
                if ((cmd_nxt == d2cd_pkg::D2CD_CMD_WR) || (cmd_nxt == d2cd_pkg::D2CD_CMD_RD)) begin
                    lk_burst_r <= 1'b1;
                    if (lk_burst_r) begin
                        lk_evt_r.cmd <= d2cd_pkg::D2CD_CMD_ILL;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // core side: toggle crossing
    // ----------------------------------------
    // event words change on the same link edge as the toggle and hold for at least a full link period after it
    logic                       tg_s1_r;
    logic                       tg_s2_r;
    logic                       tg_s3_r;
    logic                       evt_stb;
    d2cd_pkg::d2cd_event_type   ev;
    logic [7:0]                 rd_cnt_r;

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            tg_s1_r <= 1'b0;
            tg_s2_r <= 1'b0;
            tg_s3_r <= 1'b0;
        end else begin
            tg_s1_r <= lk_tgl_r;
            tg_s2_r <= tg_s1_r;
            tg_s3_r <= tg_s2_r;
        end
    end

    assign evt_stb = tg_s2_r ^ tg_s3_r;
    assign ev      = lk_evt_r;

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            EVT_TGL <= 1'b0;
            EVT     <= '0;
        end else if (evt_stb) begin
            EVT_TGL <= ~EVT_TGL;
            EVT     <= ev;
        end
    end

    // ----------------------------------------
    // extended mode registers
    // ----------------------------------------
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            REFR_OPT    <= '0;
            REFR_VALID  <= 1'b0;
            SPARE_VALID <= 1'b0;
        end else if (evt_stb && ev.cmd == d2cd_pkg::D2CD_CMD_MODE_SET) begin
            if (ev.bank == d2cd_pkg::SEL_REFR) begin
                REFR_OPT.high_temp_refresh_rate       <= ev.addr[d2cd_pkg::TEMP_BIT];
                REFR_OPT.partial_array_refresh_select <= ev.addr[d2cd_pkg::PART_SEL_HI:0];
                REFR_VALID <= 1'b1;
            end
            if (ev.bank == d2cd_pkg::SEL_SPARE) begin
                SPARE_VALID <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // power state, termination, read delay
    // ----------------------------------------
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            SELF_REFRESH <= 1'b0;
            POWER_DOWN   <= 1'b0;
            ILLEGAL      <= 1'b0;
        end else if (evt_stb) begin
            unique case (ev.cmd)
                d2cd_pkg::D2CD_CMD_SRE: SELF_REFRESH <= 1'b1;
                d2cd_pkg::D2CD_CMD_SRX: SELF_REFRESH <= 1'b0;
                d2cd_pkg::D2CD_CMD_PDE: POWER_DOWN   <= 1'b1;
                d2cd_pkg::D2CD_CMD_PDX: POWER_DOWN   <= 1'b0;
                d2cd_pkg::D2CD_CMD_ILL: ILLEGAL      <= 1'b1;
                default: ;
            endcase
        end
    end

    // termination request is a slow pin level, so it is brought in through two flops
    logic                       odt_s1_r;
    logic                       odt_s2_r;

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            odt_s1_r <= 1'b0;
            odt_s2_r <= 1'b0;
        end else begin
            odt_s1_r <= ODT;
            odt_s2_r <= odt_s1_r;
        end
    end

    // odt pin only gates termination; it never touches power state
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ODT_EN <= 1'b0;
        end else begin
            ODT_EN <= odt_s2_r && !SELF_REFRESH;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rd_cnt_r   <= '0;
            READ_READY <= 1'b1;
        end else if (evt_stb && ev.cmd == d2cd_pkg::D2CD_CMD_SRX) begin
            rd_cnt_r   <= d2cd_pkg::SR_EXIT_CNT;
            READ_READY <= 1'b0;
        end else if (rd_cnt_r != '0) begin
            rd_cnt_r   <= rd_cnt_r - 8'h01;
            READ_READY <= (rd_cnt_r == 8'h01);
        end
    end

    // ----------------------------------------
    // core-side checks
    // ----------------------------------------
    // the read delay counts core cycles, so a slower core clock stretches it in memory clocks
    a_refr_write: assert property (@(posedge MCLK) disable iff (SRST)
        (evt_stb && ev.cmd == d2cd_pkg::D2CD_CMD_MODE_SET && ev.bank == d2cd_pkg::SEL_REFR)
        |=> REFR_VALID && REFR_OPT.high_temp_refresh_rate == $past(ev.addr[d2cd_pkg::TEMP_BIT]))
        else $error("refresh-options write not captured");
    a_part_field: assert property (@(posedge MCLK) disable iff (SRST)
        (evt_stb && ev.cmd == d2cd_pkg::D2CD_CMD_MODE_SET && ev.bank == d2cd_pkg::SEL_REFR)
        |=> REFR_OPT.partial_array_refresh_select == $past(ev.addr[d2cd_pkg::PART_SEL_HI:0]))
        else $error("partial array select not captured");
    a_spare_write: assert property (@(posedge MCLK) disable iff (SRST)
        (evt_stb && ev.cmd == d2cd_pkg::D2CD_CMD_MODE_SET && ev.bank == d2cd_pkg::SEL_SPARE) |=> SPARE_VALID)
        else $error("spare register write not recorded");
    a_odt_self: assert property (@(posedge MCLK) disable iff (SRST)
        SELF_REFRESH |=> !ODT_EN)
        else $error("termination active in self refresh");
    a_odt_follow: assert property (@(posedge MCLK) disable iff (SRST)
        (odt_s2_r && !SELF_REFRESH) |=> ODT_EN)
        else $error("termination request not followed");
    a_exit_delay: assert property (@(posedge MCLK) disable iff (SRST)
        (evt_stb && ev.cmd == d2cd_pkg::D2CD_CMD_SRX) |=> !READ_READY [*8])
        else $error("read ready too soon after exit");
    a_exit_ready: assert property (@(posedge MCLK) disable iff (SRST)
        (evt_stb && ev.cmd == d2cd_pkg::D2CD_CMD_SRX) |-> ##[200:201] READ_READY)
        else $error("read ready late after exit");
    a_exit_clear: assert property (@(posedge MCLK) disable iff (SRST)
        (evt_stb && ev.cmd == d2cd_pkg::D2CD_CMD_SRX) |=> !SELF_REFRESH)
        else $error("self refresh not left");
    a_self_enter: assert property (@(posedge MCLK) disable iff (SRST)
        (evt_stb && ev.cmd == d2cd_pkg::D2CD_CMD_SRE) |=> SELF_REFRESH)
        else $error("self refresh not entered");
    a_pd_exit: assert property (@(posedge MCLK) disable iff (SRST)
        (evt_stb && ev.cmd == d2cd_pkg::D2CD_CMD_PDX) |=> !POWER_DOWN)
        else $error("power down not left");
    a_illegal_stuck: assert property (@(posedge MCLK) disable iff (SRST)
        ILLEGAL |=> ILLEGAL)
        else $error("illegal flag cleared");

    // ----------------------------------------
    // link-side checks
    // ----------------------------------------
    a_pd_enter: assert property (@(posedge CK_LINK) disable iff (link_rst_r)
        (cke_prev_r && !CKE && !lk_self_r && !lk_pd_r && CS_N) |=> lk_pd_r)
        else $error("power down not entered");
    a_cmd_decode: assert property (@(posedge CK_LINK) disable iff (link_rst_r)
        (cke_prev_r && CKE && !lk_self_r && !lk_pd_r && !CS_N && RAS_N && !CAS_N && WE_N)
        |=> lk_evt_r.cmd inside {d2cd_pkg::D2CD_CMD_RD, d2cd_pkg::D2CD_CMD_ILL})
        else $error("read not decoded");
    a_mode_decode: assert property (@(posedge CK_LINK) disable iff (link_rst_r)
        (cke_prev_r && CKE && !lk_self_r && !lk_pd_r && !CS_N && !RAS_N && !CAS_N && !WE_N)
        |=> lk_evt_r.cmd == d2cd_pkg::D2CD_CMD_MODE_SET)
        else $error("mode register write not decoded");
    a_precharge_all: assert property (@(posedge CK_LINK) disable iff (link_rst_r)
        (cke_prev_r && CKE && !lk_self_r && !lk_pd_r && !CS_N && !RAS_N && CAS_N && !WE_N && addr_m[d2cd_pkg::AP_BIT])
        |=> lk_evt_r.cmd == d2cd_pkg::D2CD_CMD_PREA)
        else $error("precharge all not decoded");
    a_burst_cut: assert property (@(posedge CK_LINK) disable iff (link_rst_r)
        (lk_burst_r && (cmd_nxt == d2cd_pkg::D2CD_CMD_WR || cmd_nxt == d2cd_pkg::D2CD_CMD_RD))
        |=> lk_evt_r.cmd == d2cd_pkg::D2CD_CMD_ILL)
        else $error("interrupted burst not flagged");
    a_evt_bank: assert property (@(posedge CK_LINK) disable iff (link_rst_r)
        (cmd_nxt != d2cd_pkg::D2CD_CMD_NONE) |=> lk_evt_r.bank == $past(BA))
        else $error("bank not captured with command");

    c_refr: cover property (@(posedge MCLK) disable iff (SRST) $rose(REFR_VALID));
    c_self: cover property (@(posedge MCLK) disable iff (SRST) $fell(SELF_REFRESH));
    c_pd:   cover property (@(posedge MCLK) disable iff (SRST) $rose(POWER_DOWN));
    c_rdy:  cover property (@(posedge MCLK) disable iff (SRST) $rose(READ_READY));
    c_ill:  cover property (@(posedge MCLK) disable iff (SRST) $rose(ILLEGAL));

endmodule : d2cd_top

// ---- bench/d2cd_ctrl_model.sv ----
// controller model: drives the command and address pins on the link clock
`timescale 1ns/1ps
module d2cd_ctrl_model #(
    parameter int MODE_SET_GAP = 2
) (
    input  wire logic        ck_link,
    output logic             cke,
    output logic             cs_n,
    output logic             ras_n,
    output logic             cas_n,
    output logic             we_n,
    output logic [2:0]       ba,
    output logic [13:0]      addr
);
    // power-up: cke low, NOP, every don't-care pin at a defined level
    initial begin
        cke  = 1'b0;
        {cs_n, ras_n, cas_n, we_n} = 4'h7;
        ba   = 3'h0;
        addr = 14'h0000;
    end

    // command held for n link edges, then NOP; cke keeps the level given
    task automatic issue(input logic k, input logic [3:0] s, input logic [2:0] b, input logic [13:0] a,
                         input int n);
        @(negedge ck_link);
        cke  = k;
        {cs_n, ras_n, cas_n, we_n} = s;
        ba   = b;
        addr = a;
        repeat (n) @(negedge ck_link);
        {cs_n, ras_n, cas_n, we_n} = 4'h7;
        ba   = 3'h0;
        addr = 14'h0000;
        if (s == 4'h0) begin
            repeat (MODE_SET_GAP) @(negedge ck_link);
        end
    endtask : issue
endmodule : d2cd_ctrl_model

// ---- bench/tb_top.sv ----
// testbench for the command decoder: command table, register codes, power states, faults
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [3:0]  strb;
        logic [2:0]  bank;
        logic [13:0] addr;
        logic [3:0]  cmd;
        logic        ap;
        logic [13:0] mask;
    } d2cd_row_type;

    logic                       mclk, srst, ck_link, odt;
    logic                       cke, cs_n, ras_n, cas_n, we_n;
    logic [2:0]                 ba;
    logic [13:0]                addr;
    logic                       evt_tgl, refr_valid, spare_valid, self_refresh, power_down;
    logic                       odt_en, read_ready, illegal;
    d2cd_pkg::d2cd_event_type   evt;
    d2cd_pkg::d2cd_refr_type    refr_opt;
    int                         err_count = 0;
    int                         comparisons = 0;
    int                         cnt;
    int                         low_cnt = 0;
    logic                       old_tgl;

    // strobes {cs,ras,cas,we}, bank, address, expected code, auto-precharge, address bits compared
    localparam d2cd_row_type ROWS [11] = '{
        '{4'h0, 3'h2, 14'h0084, 4'h1, 1'b0, 14'h3FFF},
        '{4'h0, 3'h3, 14'h0000, 4'h1, 1'b0, 14'h3FFF},
        '{4'h0, 3'h0, 14'h0042, 4'h1, 1'b0, 14'h3FFF},
        '{4'h1, 3'h0, 14'h0000, 4'h2, 1'b0, 14'h0000},
        '{4'h3, 3'h5, 14'h3FFF, 4'h5, 1'b1, 14'h3FFF},
        '{4'h4, 3'h5, 14'h07FF, 4'h8, 1'b1, 14'h03FF},
        '{4'h5, 3'h5, 14'h0155, 4'h9, 1'b0, 14'h03FF},
        '{4'h5, 3'h5, 14'h0401, 4'h9, 1'b1, 14'h03FF},
        '{4'h4, 3'h5, 14'h0200, 4'h8, 1'b0, 14'h03FF},
        '{4'h2, 3'h5, 14'h0000, 4'h6, 1'b0, 14'h0000},
        '{4'h2, 3'h0, 14'h0400, 4'h7, 1'b1, 14'h0000}
    };

    d2cd_ctrl_model d2cd_ctrl_model_inst (.ck_link(ck_link), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));
    d2cd_top #(.X16_ORG(1'b0)) d2cd_top_inst (.MCLK(mclk), .SRST(srst), .CK_LINK(ck_link), .CKE(cke),
        .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .ODT(odt), .BA(ba), .ADDR(addr),
        .EVT_TGL(evt_tgl), .EVT(evt), .REFR_OPT(refr_opt), .REFR_VALID(refr_valid), .SPARE_VALID(spare_valid),
        .SELF_REFRESH(self_refresh), .POWER_DOWN(power_down), .ODT_EN(odt_en), .READ_READY(read_ready),
        .ILLEGAL(illegal));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // link clock free-running, phase unrelated to the core clock
    initial begin
        ck_link = 1'b0;
        #37;
        forever #80 ck_link = ~ck_link;
    end
    // core cycles with read_ready low; the run holds a single self-refresh exit
    always @(negedge mclk) begin
        if (read_ready === 1'b0) begin
            low_cnt++;
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    task automatic wait_evt(input logic old, input logic [3:0] exp);
        int w;
        w = 0;
        while (evt_tgl === old && w < 200) begin
            @(negedge mclk);
            w++;
        end
        if (w >= 200) begin
            err_count++;
            $display("CHECK FAILED evt_tgl expected toggle seen none");
            print_verdict();
        end
        repeat (2) @(negedge mclk);
        chk("cmd", exp, evt.cmd);
    endtask : wait_evt

    task automatic send(input logic k, input logic [3:0] s, input logic [2:0] b, input logic [13:0] a,
                        input int n, input logic [3:0] exp);
        logic old;
        old = evt_tgl;
        d2cd_ctrl_model_inst.issue(k, s, b, a, n);
        wait_evt(old, exp);
    endtask : send

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        srst = 1'b1;
        odt  = 1'b0;
        // reset spans several link edges so the link-side synchroniser sees it
        repeat (12) @(posedge ck_link);
        @(negedge mclk);
        chk("evt_tgl", 0, evt_tgl);
        chk("read_ready", 1, read_ready);
        chk("refr_valid", 0, refr_valid);
        srst = 1'b0;
        repeat (3) @(posedge ck_link);
        d2cd_ctrl_model_inst.issue(1'b1, 4'h7, 3'h0, 14'h0000, 2);
        for (int i = 0; i < 11; i++) begin
            send(1'b1, ROWS[i].strb, ROWS[i].bank, ROWS[i].addr, 1, ROWS[i].cmd);
            chk("auto_pre", ROWS[i].ap, evt.auto_pre);
            chk("bank", ROWS[i].bank, evt.bank);
            chk("addr", ROWS[i].addr & ROWS[i].mask, evt.addr & ROWS[i].mask);
        end
        chk("spare_valid", 1, spare_valid);
        for (int i = 0; i < 8; i++) begin
            send(1'b1, 4'h0, 3'h2, {6'h00, i[0], 4'h0, i[2:0]}, 1, 4'h1);
            chk("refr_opt", {i[0], i[2:0]}, refr_opt);
            chk("refr_valid", 1, refr_valid);
        end
        odt = 1'b1;
        repeat (4) @(negedge mclk);
        chk("odt_en", 1, odt_en);
        send(1'b0, 4'h1, 3'h0, 14'h0000, 1, 4'h3);
        chk("self_refresh", 1, self_refresh);
        chk("odt_en", 0, odt_en);
        repeat (4) @(posedge ck_link);
        send(1'b1, 4'h7, 3'h0, 14'h0000, 1, 4'h4);
        chk("self_refresh", 0, self_refresh);
        cnt = 0;
        while (read_ready !== 1'b1 && cnt < 400) begin
            @(negedge mclk);
            cnt++;
        end
        if (cnt >= 400) begin
            err_count++;
            $display("CHECK FAILED read_ready expected high seen low");
            print_verdict();
        end
        chk("read_delay", d2cd_pkg::SELF_REFRESH_EXIT_READ_DELAY_CLK, low_cnt);
        repeat (200) @(posedge ck_link);
        send(1'b0, 4'h7, 3'h0, 14'h0000, 1, 4'hA);
        chk("power_down", 1, power_down);
        repeat (3) @(posedge ck_link);
        send(1'b1, 4'h7, 3'h0, 14'h0000, 1, 4'hB);
        chk("power_down", 0, power_down);
        old_tgl = evt_tgl;
        fork
            d2cd_ctrl_model_inst.issue(1'b1, 4'h5, 3'h1, 14'h0010, 2);
            begin
                wait_evt(old_tgl, 4'h9);
                wait_evt(evt_tgl, 4'hC);
            end
        join
        chk("illegal", 1, illegal);
        @(negedge mclk);
        srst = 1'b1;
        repeat (12) @(posedge ck_link);
        @(negedge mclk);
        chk("illegal", 0, illegal);
        chk("refr_valid", 0, refr_valid);
        print_verdict();
    end
endmodule : tb_top
